// ### hw/ebmc_pkg.sv
// package for the external bus misc control register group
// assumes a single AHB-Lite slave with 32-bit data, 125 MHz hclk
`default_nettype none
package ebmc_pkg;
	// printed offsets are not all multiples of four: they are indexes
	localparam logic [7:0] IDX_PULL_ENABLE_CTRL     = 8'h0c;
	localparam logic [7:0] IDX_DRIVE_STRENGTH_CTRL  = 8'h0d;
	localparam logic [7:0] IDX_BUS_CLOCK_STRETCH    = 8'h0e;
	localparam logic [7:0] IDX_RESERVED_LOCATION    = 8'h0f;
	localparam logic [7:0] IDX_EXT_INTERRUPT_CTRL   = 8'h1e;
	// port bit positions in pull and drive registers
	localparam int BIT_PORT_K = 7;
	localparam int BIT_PORT_E = 4;
	localparam int BIT_PORT_B = 1;
	localparam int BIT_PORT_A = 0;
	localparam logic [7:0] PORT_MASK = 8'h93;
	localparam int BIT_E_STRETCH = 0;
	localparam int BIT_IRQ_EDGE  = 7;
	localparam int BIT_IRQ_CONN  = 6;
	// port e pins under the pull enable, and the pins outside it pulled in reset
	localparam logic [7:0] PORT_E_PULL_MASK = 8'h9f;
	localparam logic [7:0] PORT_E_RESET_PULL = 8'h60;
	// reset values, not printed: all cleared
	localparam logic [7:0] RST_PULL  = 8'h00;
	localparam logic [7:0] RST_DRIVE = 8'h00;
	localparam logic       RST_BIT   = 1'b0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage
`default_nettype wire

// ### hw/ebmc_regs.sv
// external bus misc control registers behind an AHB-Lite slave
// assumes mode bits come from the mode register, pins sync to hclk
// Function
// - pull register: enables at bits 7,4,1,0 for ports k,e,b,a
// - pull acts only on pins currently configured as inputs
// - port e pull enable covers pins 7 and 4:0 only
// - port e pins 5 and 6 pulled only while reset is active
// - drive register: reduced drive select per port, same bit layout
// - reduced drive applies whatever function uses the pins
// - pull and drive registers read and write at any time
// - registers at indexes 0c,0d,0e,0f,1e from a relocatable base
// - in expanded or peripheral modes registers absent, passed outside
// - reserved index 0f reads zero, writes ignored
// - stretch bit write once in normal/emulation, anytime in special
// - stretch clear: e free runs; set: stretch external, low on internal accesses without int_visible
// - stretch bit has no effect in single-chip modes
// - edge-sense bit write anytime special, write once otherwise
// - edge-sense clear: interrupt pin is active-low level request
// - edge-sense set: falling edges latched until reset or service
// - pin-connect bit read/write anytime; clear disconnects the pin
// - pin-connect clear holds the edge latch disabled
// - mode select bits 7:5 of mode register give operating mode
//
// Design decision made here: the AHB-Lite interface to the registers.
`default_nettype none
module ebmc_regs #(
	parameter logic [31:0] BASE_RESET = 32'h0000_0000
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [31:0] register_base_init,
	input  wire logic [2:0]  mode_select_bits,
	output logic             ext_pass_through,
	input  wire logic [7:0]  dir_out_k,
	input  wire logic [7:0]  dir_out_e,
	input  wire logic [7:0]  dir_out_b,
	input  wire logic [7:0]  dir_out_a,
	output logic      [7:0]  pull_k,
	output logic      [7:0]  pull_e,
	output logic      [7:0]  pull_b,
	output logic      [7:0]  pull_a,
	output logic             low_drive_k,
	output logic             low_drive_e,
	output logic             low_drive_b,
	output logic             low_drive_a,
	input  wire logic        ext_access,
	input  wire logic        ext_stretch,
	input  wire logic        int_visible,
	input  wire logic        e_free,
	output logic             e_clock_out,
	input  wire logic        irq_pin_n,
	input  wire logic        irq_ack,
	output logic             irq_request
);
	// mode decode
	wire mode_special     = ~mode_select_bits[2] & ~mode_select_bits[0];
	wire mode_peripheral  = (mode_select_bits == 3'h6);
	wire mode_expanded    = mode_select_bits[0];
	wire mode_single_chip = ~mode_select_bits[1] & ~mode_select_bits[0];
	wire regs_in_map      = ~(mode_expanded | mode_peripheral);

	// address phase capture
	wire [31:0] rel_addr  = haddr - register_base_init;
	wire        addr_hit  = rel_addr[31:8] == 24'h0;
	wire        req       = hsel & hready & htrans[1] & regs_in_map;
	wire        hit       = addr_hit & (rel_addr[1:0] == 2'h0);
	logic       wr_q;
	logic [7:0] idx_q;
	logic       phase_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q    <= 1'b0;
			idx_q   <= 8'h00;
			phase_q <= 1'b0;
		end else begin
			wr_q    <= req & hwrite & hit;
			idx_q   <= rel_addr[9:2];
			phase_q <= req & hit;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ext_pass_through = ~regs_in_map;

	wire wr_pull  = wr_q & (idx_q == ebmc_pkg::IDX_PULL_ENABLE_CTRL);
	wire wr_drv   = wr_q & (idx_q == ebmc_pkg::IDX_DRIVE_STRENGTH_CTRL);
	wire wr_e_clock_stretch  = wr_q & (idx_q == ebmc_pkg::IDX_BUS_CLOCK_STRETCH);
	wire wr_irq   = wr_q & (idx_q == ebmc_pkg::IDX_EXT_INTERRUPT_CTRL);

	// registers
	logic [7:0] pull_q;
	logic [7:0] drv_q;
	logic       e_clock_stretch_q;
	logic       e_clock_stretch_once_q;
	logic       edge_q;
	logic       edge_once_q;
	logic       conn_q;
	wire e_clock_stretch_ok = mode_special | ~e_clock_stretch_once_q;
	wire edge_ok = mode_special | ~edge_once_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pull_q      <= ebmc_pkg::RST_PULL;
			drv_q       <= ebmc_pkg::RST_DRIVE;
			e_clock_stretch_q      <= ebmc_pkg::RST_BIT;
			e_clock_stretch_once_q <= 1'b0;
			edge_q      <= ebmc_pkg::RST_BIT;
			edge_once_q <= 1'b0;
			conn_q      <= ebmc_pkg::RST_BIT;
		end else begin
			if (wr_pull)
				pull_q <= hwdata[7:0] & ebmc_pkg::PORT_MASK;
			if (wr_drv)
				drv_q <= hwdata[7:0] & ebmc_pkg::PORT_MASK;
			if (wr_e_clock_stretch && e_clock_stretch_ok) begin
				e_clock_stretch_q      <= hwdata[ebmc_pkg::BIT_E_STRETCH];
				e_clock_stretch_once_q <= e_clock_stretch_once_q | ~mode_special;
			end
			if (wr_irq && edge_ok) begin
				edge_q      <= hwdata[ebmc_pkg::BIT_IRQ_EDGE];
				edge_once_q <= edge_once_q | ~mode_special;
			end
			if (wr_irq)
				conn_q <= hwdata[ebmc_pkg::BIT_IRQ_CONN];
		end
	end

	// read data, reserved and unmapped words read zero
	logic [7:0] rd_byte;
	always_comb begin
		unique case (idx_q)
		ebmc_pkg::IDX_PULL_ENABLE_CTRL:    rd_byte = pull_q;
		ebmc_pkg::IDX_DRIVE_STRENGTH_CTRL: rd_byte = drv_q;
		ebmc_pkg::IDX_BUS_CLOCK_STRETCH:   rd_byte = {7'h00, e_clock_stretch_q};
		ebmc_pkg::IDX_EXT_INTERRUPT_CTRL:  rd_byte = {edge_q, conn_q, 6'h00};
		default:                           rd_byte = 8'h00;
		endcase
	end
	assign hrdata = {24'h000000, phase_q ? rd_byte : 8'h00};

	// pull outputs: reset forces port e pins 5 and 6 on
	function automatic logic [7:0] pull_of(input logic en,
		input logic [7:0] dir);
		pull_of = {8{en}} & ~dir;
	endfunction
	assign pull_k = pull_of(pull_q[ebmc_pkg::BIT_PORT_K], dir_out_k);
	assign pull_b = pull_of(pull_q[ebmc_pkg::BIT_PORT_B], dir_out_b);
	assign pull_a = pull_of(pull_q[ebmc_pkg::BIT_PORT_A], dir_out_a);
	assign pull_e = (pull_of(pull_q[ebmc_pkg::BIT_PORT_E], dir_out_e)
		& ebmc_pkg::PORT_E_PULL_MASK)
		| (hresetn ? 8'h00 : ebmc_pkg::PORT_E_RESET_PULL);
	// drive select is per port, independent of pin function
	assign low_drive_k = drv_q[ebmc_pkg::BIT_PORT_K];
	assign low_drive_e = drv_q[ebmc_pkg::BIT_PORT_E];
	assign low_drive_b = drv_q[ebmc_pkg::BIT_PORT_B];
	assign low_drive_a = drv_q[ebmc_pkg::BIT_PORT_A];

	// e clock shaping, stretch ignored in single-chip modes
	wire stretch_on = e_clock_stretch_q & ~mode_single_chip;
	assign e_clock_out = !stretch_on ? e_free :
		(ext_access ? (e_free | ext_stretch) :
		(int_visible ? e_free : 1'b0));

	// external interrupt: level or latched falling edge
	logic pin_q;
	logic edge_latch_q;
	wire  fall = pin_q & ~irq_pin_n;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_q        <= 1'b1;
			edge_latch_q <= 1'b0;
		end else begin
			pin_q <= irq_pin_n;
			if (!conn_q || !edge_q)
				edge_latch_q <= 1'b0;
			else if (fall)
				edge_latch_q <= 1'b1;
			else if (irq_ack)
				edge_latch_q <= 1'b0;
		end
	end
	assign irq_request = conn_q & (edge_q ? edge_latch_q : ~irq_pin_n);

	property p_latch_set;
		@(posedge hclk) disable iff (!hresetn)
		(conn_q && edge_q && fall) |=> edge_latch_q;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("edge lost");
	property p_ack_clear;
		@(posedge hclk) disable iff (!hresetn)
		(irq_ack && !fall && edge_latch_q) |=> !edge_latch_q;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("ack ignored");
	property p_conn_off;
		@(posedge hclk) disable iff (!hresetn)
		!conn_q |=> !edge_latch_q;
	endproperty
	a_conn_off: assert property (p_conn_off) else $error("pin leaks");
	property p_level;
		@(posedge hclk) disable iff (!hresetn)
		(conn_q && !edge_q) |-> irq_request == !irq_pin_n;
	endproperty
	a_level: assert property (p_level) else $error("level wrong");
	property p_once;
		@(posedge hclk) disable iff (!hresetn)
		(wr_e_clock_stretch && e_clock_stretch_once_q && !mode_special) |=> $stable(e_clock_stretch_q);
	endproperty
	a_once: assert property (p_once) else $error("second write");
	property p_edge_once;
		@(posedge hclk) disable iff (!hresetn)
		(wr_irq && edge_once_q && !mode_special) |=> $stable(edge_q);
	endproperty
	a_edge_once: assert property (p_edge_once) else $error("edge rewrite");
	property p_pull_out;
		@(posedge hclk) disable iff (!hresetn)
		(pull_a & dir_out_a) == 8'h00 && (pull_b & dir_out_b) == 8'h00
		&& (pull_k & dir_out_k) == 8'h00 && (pull_e & dir_out_e) == 8'h00;
	endproperty
	a_pull_out: assert property (p_pull_out) else $error("bad pull");
	property p_pull_wr;
		@(posedge hclk) disable iff (!hresetn)
		wr_pull |=> pull_q == ($past(hwdata[7:0]) & 8'h93);
	endproperty
	a_pull_wr: assert property (p_pull_wr) else $error("pull not stored");
	property p_rsvd;
		@(posedge hclk) disable iff (!hresetn)
		(phase_q && idx_q == 8'h0f) |-> hrdata == 32'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved nonzero");
	property p_absent;
		@(posedge hclk) disable iff (!hresetn)
		mode_expanded |=> !wr_q;
	endproperty
	a_absent: assert property (p_absent) else $error("write when absent");
	property p_absent_rd;
		@(posedge hclk) disable iff (!hresetn)
		!regs_in_map |=> !phase_q && hrdata == 32'h0;
	endproperty
	a_absent_rd: assert property (p_absent_rd)
		else $error("read answered while absent");
	property p_latch_hold;
		@(posedge hclk) disable iff (!hresetn)
		(conn_q && edge_q && edge_latch_q && !irq_ack) |=> edge_latch_q;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("edge latch dropped");
	property p_conn_irq;
		@(posedge hclk) disable iff (!hresetn)
		!conn_q |-> !irq_request;
	endproperty
	a_conn_irq: assert property (p_conn_irq)
		else $error("request while pin disconnected");
	property p_e_clock_stretch_special;
		@(posedge hclk) disable iff (!hresetn)
		(wr_e_clock_stretch && mode_special) |=>
		e_clock_stretch_q == $past(hwdata[ebmc_pkg::BIT_E_STRETCH]);
	endproperty
	a_e_clock_stretch_special: assert property (p_e_clock_stretch_special)
		else $error("stretch write lost in special mode");
	property p_edge_special;
		@(posedge hclk) disable iff (!hresetn)
		(wr_irq && mode_special) |=>
		edge_q == $past(hwdata[ebmc_pkg::BIT_IRQ_EDGE]);
	endproperty
	a_edge_special: assert property (p_edge_special)
		else $error("edge-sense write lost in special mode");
	property p_once_flag;
		@(posedge hclk) disable iff (!hresetn)
		(wr_e_clock_stretch && !mode_special) |=> e_clock_stretch_once_q;
	endproperty
	a_once_flag: assert property (p_once_flag)
		else $error("write-once flag not set");
	property p_conn_wr;
		@(posedge hclk) disable iff (!hresetn)
		wr_irq |=> conn_q == $past(hwdata[ebmc_pkg::BIT_IRQ_CONN]);
	endproperty
	a_conn_wr: assert property (p_conn_wr)
		else $error("pin-connect write lost");
	property p_drv_wr;
		@(posedge hclk) disable iff (!hresetn)
		wr_drv |=> drv_q == ($past(hwdata[7:0]) & ebmc_pkg::PORT_MASK);
	endproperty
	a_drv_wr: assert property (p_drv_wr)
		else $error("drive select not stored");
	property p_pull_on_a;
		@(posedge hclk) disable iff (!hresetn)
		pull_q[ebmc_pkg::BIT_PORT_A] |-> pull_a == ~dir_out_a;
	endproperty
	a_pull_on_a: assert property (p_pull_on_a)
		else $error("port a input not pulled");
	property p_pull_off_k;
		@(posedge hclk) disable iff (!hresetn)
		!pull_q[ebmc_pkg::BIT_PORT_K] |-> pull_k == 8'h00;
	endproperty
	a_pull_off_k: assert property (p_pull_off_k)
		else $error("port k pulled while disabled");
	property p_pull_e_on;
		@(posedge hclk) disable iff (!hresetn)
		pull_q[ebmc_pkg::BIT_PORT_E] |->
		(pull_e & ebmc_pkg::PORT_E_PULL_MASK) ==
		(~dir_out_e & ebmc_pkg::PORT_E_PULL_MASK);
	endproperty
	a_pull_e_on: assert property (p_pull_e_on)
		else $error("port e governed pins wrong");
	property p_pull_e_pins;
		@(posedge hclk) disable iff (!hresetn)
		(pull_e & ebmc_pkg::PORT_E_RESET_PULL) == 8'h00;
	endproperty
	a_pull_e_pins: assert property (p_pull_e_pins)
		else $error("port e pins 5 6 pulled after reset");
	property p_pull_rst;
		@(posedge hclk)
		!hresetn |-> (pull_e & ebmc_pkg::PORT_E_RESET_PULL) ==
		ebmc_pkg::PORT_E_RESET_PULL;
	endproperty
	a_pull_rst: assert property (p_pull_rst)
		else $error("port e pins 5 6 not pulled in reset");
	property p_rsvd_wr;
		@(posedge hclk) disable iff (!hresetn)
		(wr_q && idx_q == ebmc_pkg::IDX_RESERVED_LOCATION) |=>
		$stable(pull_q) && $stable(drv_q) && $stable(e_clock_stretch_q)
		&& $stable(edge_q) && $stable(conn_q);
	endproperty
	a_rsvd_wr: assert property (p_rsvd_wr)
		else $error("reserved write changed a register");
	property p_e_clock_stretch_free;
		@(posedge hclk) disable iff (!hresetn)
		!e_clock_stretch_q |-> e_clock_out == e_free;
	endproperty
	a_e_clock_stretch_free: assert property (p_e_clock_stretch_free)
		else $error("e clock not free running");
	property p_single;
		@(posedge hclk) disable iff (!hresetn)
		mode_single_chip |-> e_clock_out == e_free;
	endproperty
	a_single: assert property (p_single)
		else $error("stretch acts in single-chip mode");
	property p_stretch_hi;
		@(posedge hclk) disable iff (!hresetn)
		(stretch_on && ext_access && ext_stretch) |-> e_clock_out;
	endproperty
	a_stretch_hi: assert property (p_stretch_hi)
		else $error("e clock low in stretched access");
	property p_int_low;
		@(posedge hclk) disable iff (!hresetn)
		(stretch_on && !ext_access && !int_visible) |-> !e_clock_out;
	endproperty
	a_int_low: assert property (p_int_low)
		else $error("e clock high in hidden internal access");
endmodule
`default_nettype wire

// ### testbench/ebmc_cpu.sv
// cpu core model: single-word ahb-lite transfers on the register bus
// assumes hready is the one slave's hreadyout; waits cut by bench watchdog
`default_nettype none
module ebmc_cpu (
	input  wire logic        hclk,
	input  wire logic        hready,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	output logic             rd_dp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata, rd_dp} = '0;
	end
	// called just after a rising edge; returns at the edge ending the data
	task automatic xfer(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= ebmc_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= ebmc_pkg::HSIZE_WORD;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !wr;
		do @(posedge hclk); while (hready !== 1'b1);
		rd_dp <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### testbench/ext_bus_misc_control_regs_tb.sv
// self-checking bench for the misc control register group
// assumes ebmc_pkg and ebmc_regs compiled first
`default_nettype none
module ext_bus_misc_control_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] BASE = 32'h0000_0100;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, rd_dp, pass;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, mode;
	logic [7:0] dir_k, dir_e, dir_b, dir_a, pu_k, pu_e, pu_b, pu_a, r;
	logic ld_k, ld_e, ld_b, ld_a, ext_acc, ext_str, int_vis, e_free, e_out;
	logic irq_n, irq_ack, irq_req;
	logic [31:0] exp_q[$];
	int fail_count, n_checks;
	ebmc_cpu u_cpu (.hclk(hclk), .hready(hready), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.rd_dp(rd_dp));
	ebmc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .register_base_init(BASE),
		.mode_select_bits(mode), .ext_pass_through(pass), .dir_out_k(dir_k),
		.dir_out_e(dir_e), .dir_out_b(dir_b), .dir_out_a(dir_a),
		.pull_k(pu_k), .pull_e(pu_e), .pull_b(pu_b), .pull_a(pu_a),
		.low_drive_k(ld_k), .low_drive_e(ld_e), .low_drive_b(ld_b),
		.low_drive_a(ld_a), .ext_access(ext_acc), .ext_stretch(ext_str),
		.int_visible(int_vis), .e_free(e_free), .e_clock_out(e_out),
		.irq_pin_n(irq_n), .irq_ack(irq_ack), .irq_request(irq_req));
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		u_cpu.xfer(1'b1, BASE + {22'h0, i, 2'h0}, {24'h0, d});
	endtask
	// expected read value noted now, compared by the monitor below
	task automatic rd(input logic [7:0] i, input logic [7:0] d);
		exp_q.push_back({24'h0, d});
		u_cpu.xfer(1'b0, BASE + {22'h0, i, 2'h0}, 32'h0);
	endtask
	task automatic nap(input int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		if (rd_dp && hready) begin
			check("hrdata", exp_q.pop_front(), hrdata);
		end
	end
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// about 115 cycles expected; far beyond that means a hang
	initial begin
		#200us;
		fail_count++;
		print_verdict();
	end
	initial begin
		{hresetn, mode, ext_acc, ext_str, int_vis, e_free, irq_ack} = '0;
		{dir_k, dir_e, dir_b, dir_a} = '0;
		irq_n = 1'b1;
		r = 8'($urandom(32'h3826));
		nap(6);
		check("pull_e", 32'h60, 32'(pu_e));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		nap(1);
		check("pull_e", 32'h0, 32'(pu_e));
		@(posedge hclk);
		repeat (4) begin
			r = 8'($urandom()) & ebmc_pkg::PORT_MASK;
			{dir_k, dir_e, dir_b, dir_a} <= 32'($urandom());
			wr(ebmc_pkg::IDX_PULL_ENABLE_CTRL, r);
			wr(ebmc_pkg::IDX_DRIVE_STRENGTH_CTRL, ~r);
			rd(ebmc_pkg::IDX_PULL_ENABLE_CTRL, r);
			rd(ebmc_pkg::IDX_DRIVE_STRENGTH_CTRL, ~r & 8'h93);
			nap(0);
			check("pull_k", 32'({8{r[7]}} & ~dir_k), 32'(pu_k));
			check("pull_e", 32'({8{r[4]}} & ~dir_e & 8'h9f), 32'(pu_e));
			check("pull_b", 32'({8{r[1]}} & ~dir_b), 32'(pu_b));
			check("pull_a", 32'({8{r[0]}} & ~dir_a), 32'(pu_a));
			check("low_drive", 32'({~r[7], ~r[4], ~r[1], ~r[0]}),
				32'({ld_k, ld_e, ld_b, ld_a}));
			check("hresp", 32'h0, 32'(hresp));
			@(posedge hclk);
		end
		$display("test pull and drive done");
		wr(ebmc_pkg::IDX_RESERVED_LOCATION, 8'hff);
		rd(ebmc_pkg::IDX_RESERVED_LOCATION, 8'h00);
		wr(ebmc_pkg::IDX_BUS_CLOCK_STRETCH, 8'h01);
		wr(ebmc_pkg::IDX_BUS_CLOCK_STRETCH, 8'h00);
		rd(ebmc_pkg::IDX_BUS_CLOCK_STRETCH, 8'h00);
		wr(ebmc_pkg::IDX_EXT_INTERRUPT_CTRL, 8'h40);
		irq_n <= 1'b0;
		nap(1);
		check("irq_level", 32'h1, 32'(irq_req));
		@(posedge hclk);
		irq_n <= 1'b1;
		nap(1);
		check("irq_level", 32'h0, 32'(irq_req));
		@(posedge hclk);
		$display("test special mode done");
		mode <= 3'h4;
		wr(ebmc_pkg::IDX_BUS_CLOCK_STRETCH, 8'h01);
		wr(ebmc_pkg::IDX_BUS_CLOCK_STRETCH, 8'h00);
		rd(ebmc_pkg::IDX_BUS_CLOCK_STRETCH, 8'h01);
		wr(ebmc_pkg::IDX_EXT_INTERRUPT_CTRL, 8'hc0);
		wr(ebmc_pkg::IDX_EXT_INTERRUPT_CTRL, 8'h40);
		rd(ebmc_pkg::IDX_EXT_INTERRUPT_CTRL, 8'hc0);
		{ext_acc, ext_str} <= 2'h3;
		irq_n <= 1'b0;
		nap(3);
		check("e_clock", 32'(e_free), 32'(e_out));
		check("irq_edge", 32'h1, 32'(irq_req));
		@(posedge hclk);
		irq_n <= 1'b1;
		irq_ack <= 1'b1;
		@(posedge hclk);
		irq_ack <= 1'b0;
		nap(2);
		check("irq_ack", 32'h0, 32'(irq_req));
		@(posedge hclk);
		irq_n <= 1'b0;
		wr(ebmc_pkg::IDX_EXT_INTERRUPT_CTRL, 8'h80);
		irq_n <= 1'b1;
		nap(2);
		check("irq_off", 32'h0, 32'(irq_req));
		@(posedge hclk);
		$display("test write once and irq done");
		mode <= 3'h5;
		nap(1);
		check("pass", 32'h1, 32'(pass));
		check("e_stretch", 32'h1, 32'(e_out));
		@(posedge hclk);
		ext_acc <= 1'b0;
		wr(ebmc_pkg::IDX_PULL_ENABLE_CTRL, ~r);
		rd(ebmc_pkg::IDX_PULL_ENABLE_CTRL, 8'h00);
		nap(0);
		check("e_internal", 32'h0, 32'(e_out));
		@(posedge hclk);
		{int_vis, e_free} <= 2'h3;
		nap(0);
		check("e_visible", 32'h1, 32'(e_out));
		@(posedge hclk);
		mode <= 3'h2;
		rd(ebmc_pkg::IDX_PULL_ENABLE_CTRL, r);
		$display("test expanded mode done");
		hresetn <= 1'b0;
		mode <= 3'h4;
		nap(2);
		check("pull_e", 32'(ebmc_pkg::PORT_E_RESET_PULL), 32'(pu_e));
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(ebmc_pkg::IDX_PULL_ENABLE_CTRL, ebmc_pkg::RST_PULL);
		wr(ebmc_pkg::IDX_BUS_CLOCK_STRETCH, 8'h01);
		rd(ebmc_pkg::IDX_BUS_CLOCK_STRETCH, 8'h01);
		mode <= 3'h6;
		nap(1);
		check("pass", 32'h1, 32'(pass));
		check("reads left", 32'h0, 32'(exp_q.size()));
		$display("test reset again done");
		print_verdict();
	end
endmodule
`default_nettype wire
